//--- design/mcsrx_dev.sv
// Transceiver end: samples the sync pulse, counts the six-pulse sequence,
// steers analog and digital divider alignment, and admits sample rates.
// Assumes i_core_clk is the device clock shared with the pulse source.
`timescale 1ns/100ps
module mcsrx_dev (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  mcsrx_link_if.dev link,
  input wire logic i_edge_fall,
  input wire logic i_to_ready,
  input wire logic i_restart,
  input wire logic i_to_primed,
  input wire logic i_rate_valid,
  input wire logic [mcsrx_pkg::RATE_W-1:0] i_rate_hz,
  input wire logic i_lp_tune_en,
  input wire logic [mcsrx_pkg::KHZ_W-1:0] i_lp_tune_khz,
  output logic o_analog_align,
  output logic o_digital_align,
  output logic o_clk_src_synth,
  output logic [2:0] o_pulse_count,
  output logic [2:0] o_state,
  output logic o_rate_done,
  output logic o_rate_ok,
  output logic o_rate_hp_sel,
  output logic [mcsrx_pkg::KHZ_W-1:0] o_lp_freq_khz,
  output logic o_lp_tune_err
);

  typedef struct packed {
    mcsrx_pkg::mcsrx_dev_st_t st;
    logic [2:0] cnt;
    logic [1:0] wid;
    logic samp;
    logic ana;
    logic dig;
    logic src_synth;
    logic rate_done;
    logic rate_ok;
    logic rate_hp;
    logic [mcsrx_pkg::KHZ_W-1:0] lp_khz;
    logic lp_err;
  } mcsrx_dev_s_t;

  mcsrx_dev_s_t s_q;
  mcsrx_dev_s_t s_d;
  logic neg_q;
  logic qual;
  logic [2:0] cnt_nx;
  logic [mcsrx_pkg::NZONE-1:0] in_zone;
  logic [63:0] rate_sc;
  logic rate_in_lim;
  logic rate_above_hp;
  logic lp_in_range;
  logic samp_nx;
  logic cnt_is_analog;
  logic cnt_is_synth;
  logic cnt_is_last;

  // Pulse roles must follow in order and the width counter must reach the minimum
  if (mcsrx_pkg::PULSE_ANALOG == 3'h0 || mcsrx_pkg::PULSE_SYNTH <= mcsrx_pkg::PULSE_ANALOG ||
      mcsrx_pkg::PULSE_TOTAL < mcsrx_pkg::PULSE_SYNTH || mcsrx_pkg::MIN_PULSE_CYC < 1 ||
      mcsrx_pkg::MIN_PULSE_CYC > 3) begin : g_chk
    $error("mcsrx_dev: package constants out of range");
  end

  // Falling-edge capture for the falling-edge sampling option
  // Kept apart from the state record: it is the one flop on the falling edge
  always_ff @(negedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= link.sync_pulse;
    end
  end

  // Rate scaled to units of 1/288 MHz times one million
  assign rate_sc = 64'(i_rate_hz) * 64'(mcsrx_pkg::RATE_SCALE);

  // Endpoint of the limit counts as admitted; a rate equal to the synthesizer threshold does not set rate_hp
  assign rate_in_lim = (i_rate_hz <= mcsrx_pkg::RATE_MAX_HZ);
  assign rate_above_hp = rate_sc > 64'(mcsrx_pkg::HP_LIMIT) * 64'(mcsrx_pkg::HZ_PER_MHZ);

  // Tuned frequency must lie within the synthesizer span, bounds included
  assign lp_in_range = (i_lp_tune_khz >= mcsrx_pkg::LP_MIN_KHZ) &&
    (i_lp_tune_khz <= mcsrx_pkg::LP_MAX_KHZ);

  // One dead-zone comparator per table entry, open at both ends
  for (genvar z = 0; z < mcsrx_pkg::NZONE; z++) begin : g_zone
    assign in_zone[z] =
      (rate_sc > 64'(mcsrx_pkg::ZONE_LO[z]) * 64'(mcsrx_pkg::HZ_PER_MHZ)) &&
      (rate_sc < 64'(mcsrx_pkg::ZONE_HI[z]) * 64'(mcsrx_pkg::HZ_PER_MHZ));
  end

  // A rise counts once the registered pulse has been high two cycles
  assign qual = s_q.samp && (s_q.wid == 2'(mcsrx_pkg::MIN_PULSE_CYC - 1));
  assign cnt_nx = s_q.cnt + 3'h1;

  // Only the registered copy of the line is used downstream
  assign samp_nx = i_edge_fall ? neg_q : link.sync_pulse;

  // Role of the pulse about to be counted
  assign cnt_is_analog = (cnt_nx <= mcsrx_pkg::PULSE_ANALOG);
  assign cnt_is_synth = (cnt_nx == mcsrx_pkg::PULSE_SYNTH);
  assign cnt_is_last = (cnt_nx == mcsrx_pkg::PULSE_TOTAL);

  always_comb begin
    s_d = s_q;
    s_d.ana = 1'b0;
    s_d.dig = 1'b0;
    s_d.rate_done = 1'b0;
    s_d.samp = samp_nx;
    // Width count saturates so a held line cannot count twice
    if (!s_q.samp) begin
      s_d.wid = 2'h0;
    end else if (s_q.wid != 2'h3) begin
      s_d.wid = s_q.wid + 2'h1;
    end
    case (s_q.st)
      mcsrx_pkg::MCSRX_CAL: begin
        if (i_to_ready) begin
          s_d.st = mcsrx_pkg::MCSRX_READY;
          s_d.cnt = 3'h0;
          s_d.src_synth = 1'b0;
        end
      end
      // A restart outranks a pulse counted in the same cycle
      mcsrx_pkg::MCSRX_READY, mcsrx_pkg::MCSRX_TRANS: begin
        if (i_restart) begin
          s_d.st = mcsrx_pkg::MCSRX_READY;
          s_d.cnt = 3'h0;
          s_d.src_synth = 1'b0;
        end else if (qual) begin
          s_d.cnt = cnt_nx;
          s_d.st = mcsrx_pkg::MCSRX_TRANS;
          if (cnt_is_analog) begin
            s_d.ana = 1'b1;
          end else begin
            s_d.dig = 1'b1;
          end
          if (cnt_is_synth) begin
            s_d.src_synth = 1'b1;
          end
          if (cnt_is_last) begin
            s_d.st = mcsrx_pkg::MCSRX_DONE;
          end
        end
      end
      // Further pulses are ignored here until a restart
      mcsrx_pkg::MCSRX_DONE: begin
        if (i_restart) begin
          s_d.st = mcsrx_pkg::MCSRX_READY;
          s_d.cnt = 3'h0;
          s_d.src_synth = 1'b0;
        end else if (i_to_primed) begin
          s_d.st = mcsrx_pkg::MCSRX_PRIMED;
        end
      end
      mcsrx_pkg::MCSRX_PRIMED: begin
        if (i_to_ready) begin
          s_d.st = mcsrx_pkg::MCSRX_READY;
          s_d.cnt = 3'h0;
          s_d.src_synth = 1'b0;
        end
      end
      default: begin
        s_d.st = mcsrx_pkg::MCSRX_CAL;
      end
    endcase
    if (i_rate_valid) begin
      s_d.rate_done = 1'b1;
      s_d.rate_ok = rate_in_lim && (in_zone == '0);
      s_d.rate_hp = rate_above_hp;
    end
    // Out-of-range tuning keeps the fixed frequency and flags an error
    if (!i_lp_tune_en) begin
      s_d.lp_khz = mcsrx_pkg::LP_FIXED_KHZ;
      s_d.lp_err = 1'b0;
    end else if (!lp_in_range) begin
      s_d.lp_khz = mcsrx_pkg::LP_FIXED_KHZ;
      s_d.lp_err = 1'b1;
    end else begin
      s_d.lp_khz = i_lp_tune_khz;
      s_d.lp_err = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{st: mcsrx_pkg::MCSRX_CAL, cnt: 3'h0, wid: 2'h0,
        samp: 1'b0, ana: 1'b0, dig: 1'b0, src_synth: 1'b1,
        rate_done: 1'b0, rate_ok: 1'b0, rate_hp: 1'b0,
        lp_khz: mcsrx_pkg::LP_FIXED_KHZ, lp_err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.ready = (s_q.st == mcsrx_pkg::MCSRX_READY) || (s_q.st == mcsrx_pkg::MCSRX_TRANS);
  assign link.done = (s_q.st == mcsrx_pkg::MCSRX_DONE);
  assign o_analog_align = s_q.ana;
  assign o_digital_align = s_q.dig;
  assign o_clk_src_synth = s_q.src_synth;
  assign o_pulse_count = s_q.cnt;
  assign o_state = s_q.st;
  assign o_rate_done = s_q.rate_done;
  assign o_rate_ok = s_q.rate_ok;
  assign o_rate_hp_sel = s_q.rate_hp;
  assign o_lp_freq_khz = s_q.lp_khz;
  assign o_lp_tune_err = s_q.lp_err;

endmodule

//--- design/mcsrx_pkg.sv
// Constants, state codes and rate tables for the multichip sync pulse path.
// Assumes the core clock is the shared device clock, so one reference clock
// cycle equals one core clock cycle.
package mcsrx_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WAIT_SHORT_NS = 1000;
  localparam int unsigned WAIT_LONG_NS = 100000;
  // Waits are strict minimums, so one cycle beyond the exact figure
  localparam int unsigned WAIT_SHORT_CYC = WAIT_SHORT_NS / CLK_PERIOD_NS + 1;
  localparam int unsigned WAIT_LONG_CYC = WAIT_LONG_NS / CLK_PERIOD_NS + 1;
  localparam int unsigned MIN_PULSE_CYC = 2;
  localparam logic [2:0] PULSE_TOTAL = 3'h6;
  localparam logic [2:0] PULSE_ANALOG = 3'h4;
  localparam logic [2:0] PULSE_SYNTH = 3'h5;
  localparam int unsigned TMR_W = 12;

  // Rate figures: sample rate in Hz, bounds in units of 1/288 MHz
  localparam int unsigned RATE_W = 32;
  localparam logic [RATE_W-1:0] RATE_MAX_HZ = 32'h03a98000;
  localparam logic [31:0] HZ_PER_MHZ = 32'h000f4240;
  localparam logic [15:0] RATE_SCALE = 16'h0120;
  localparam int unsigned NZONE = 14;
  localparam logic [15:0] ZONE_LO [NZONE] = '{16'h3840, 16'h2580, 16'h1c20,
    16'h12c0, 16'h0e10, 16'h0960, 16'h0708, 16'h04b0, 16'h0384, 16'h0258,
    16'h01c2, 16'h012c, 16'h00e1, 16'h0000};
  localparam logic [15:0] ZONE_HI [NZONE] = '{16'h3c00, 16'h2d00, 16'h1e00,
    16'h1680, 16'h0f00, 16'h0b40, 16'h0780, 16'h05a0, 16'h03c0, 16'h02d0,
    16'h01e0, 16'h0140, 16'h00f0, 16'h0006};
  localparam logic [15:0] HP_LIMIT = 16'h3c00;

  // Low-power synthesizer frequencies in kHz
  localparam int unsigned KHZ_W = 23;
  localparam logic [KHZ_W-1:0] LP_FIXED_KHZ = 23'h438000;
  localparam logic [KHZ_W-1:0] LP_MIN_KHZ = 23'h325aa0;
  localparam logic [KHZ_W-1:0] LP_MAX_KHZ = 23'h4c4b40;

  typedef enum logic [2:0] {
    MCSRX_CAL = 3'b000,
    MCSRX_READY = 3'b001,
    MCSRX_TRANS = 3'b010,
    MCSRX_DONE = 3'b011,
    MCSRX_PRIMED = 3'b100
  } mcsrx_dev_st_t;

  typedef enum logic [1:0] {
    MCSRX_SRC_IDLE = 2'b00,
    MCSRX_SRC_HIGH = 2'b01,
    MCSRX_SRC_WAIT = 2'b10
  } mcsrx_src_st_t;

endpackage

//--- design/mcsrx_link_if.sv
// Link between the sync pulse source and the transceiver end.
// Both ends run on the shared device clock; this carries levels only.
`timescale 1ns/100ps
interface mcsrx_link_if;
  logic sync_pulse;
  logic ready;
  logic done;

  modport dev (
    input sync_pulse,
    output ready,
    output done
  );

  modport src (
    output sync_pulse,
    input ready,
    input done
  );
endinterface

//--- design/mcsrx_src.sv
// Pulse source end: after a start request and a ready device, drives six
// sync pulses with the required widths and gaps on the device clock.
// Assumes i_core_clk is the device clock it also distributes.
`timescale 1ns/100ps
module mcsrx_src #(
  parameter int unsigned PULSE_W = mcsrx_pkg::MIN_PULSE_CYC,
  parameter int unsigned WAIT_SHORT = mcsrx_pkg::WAIT_SHORT_CYC,
  parameter int unsigned WAIT_LONG = mcsrx_pkg::WAIT_LONG_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  mcsrx_link_if.src link,
  input wire logic i_start,
  output logic o_busy,
  output logic o_seq_done
);

  if (PULSE_W < mcsrx_pkg::MIN_PULSE_CYC || PULSE_W >= (1 << mcsrx_pkg::TMR_W) ||
      WAIT_SHORT < 1 || WAIT_SHORT >= (1 << mcsrx_pkg::TMR_W) ||
      WAIT_LONG < 1 || WAIT_LONG >= (1 << mcsrx_pkg::TMR_W)) begin : g_chk
    $error("mcsrx_src: parameter out of range");
  end

  typedef struct packed {
    mcsrx_pkg::mcsrx_src_st_t st;
    logic [2:0] cnt;
    logic [mcsrx_pkg::TMR_W-1:0] tmr;
    logic pulse;
    logic fin;
  } mcsrx_src_s_t;

  mcsrx_src_s_t s_q;
  mcsrx_src_s_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.fin = 1'b0;
    case (s_q.st)
      mcsrx_pkg::MCSRX_SRC_IDLE: begin
        // Device must already be calibrated and ready
        if (i_start && link.ready) begin
          s_d.st = mcsrx_pkg::MCSRX_SRC_HIGH;
          s_d.cnt = 3'h1;
          s_d.pulse = 1'b1;
          s_d.tmr = mcsrx_pkg::TMR_W'(PULSE_W - 1);
        end
      end
      mcsrx_pkg::MCSRX_SRC_HIGH: begin
        if (s_q.tmr != '0) begin
          s_d.tmr = s_q.tmr - 1'b1;
        end else begin
          s_d.pulse = 1'b0;
          s_d.st = mcsrx_pkg::MCSRX_SRC_WAIT;
          if (s_q.cnt == mcsrx_pkg::PULSE_ANALOG || s_q.cnt == mcsrx_pkg::PULSE_SYNTH) begin
            s_d.tmr = mcsrx_pkg::TMR_W'(WAIT_LONG - 1);
          end else begin
            s_d.tmr = mcsrx_pkg::TMR_W'(WAIT_SHORT - 1);
          end
        end
      end
      mcsrx_pkg::MCSRX_SRC_WAIT: begin
        if (s_q.tmr != '0) begin
          s_d.tmr = s_q.tmr - 1'b1;
        end else if (s_q.cnt == mcsrx_pkg::PULSE_TOTAL) begin
          s_d.st = mcsrx_pkg::MCSRX_SRC_IDLE;
          s_d.fin = 1'b1;
        end else begin
          s_d.st = mcsrx_pkg::MCSRX_SRC_HIGH;
          s_d.cnt = s_q.cnt + 3'h1;
          s_d.pulse = 1'b1;
          s_d.tmr = mcsrx_pkg::TMR_W'(PULSE_W - 1);
        end
      end
      default: begin
        s_d.st = mcsrx_pkg::MCSRX_SRC_IDLE;
        s_d.pulse = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{st: mcsrx_pkg::MCSRX_SRC_IDLE, cnt: 3'h0,
        tmr: '0, pulse: 1'b0, fin: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sync_pulse = s_q.pulse;
  assign o_busy = (s_q.st != mcsrx_pkg::MCSRX_SRC_IDLE);
  assign o_seq_done = s_q.fin;

endmodule

//--- testbench/mcsrx_asserts.sv
// Checker for the sync pulse link and the device end outputs.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/100ps
module mcsrx_asserts (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic sync_pulse,
  input wire logic done,
  input wire logic i_restart,
  input wire logic i_rate_valid,
  input wire logic o_analog_align,
  input wire logic o_digital_align,
  input wire logic o_clk_src_synth,
  input wire logic [2:0] o_pulse_count,
  input wire logic [2:0] o_state,
  input wire logic o_rate_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_restart;
    i_restart && o_state inside {3'h1, 3'h2, 3'h3};
  endsequence
  sequence s_cleared;
    o_pulse_count == 3'h0 && o_state == 3'h1;
  endsequence
  a_restart_clears: assert property (s_restart |=> s_cleared)
    else $error("restart left count or state");
  a_one_kind: assert property (!(o_analog_align && o_digital_align))
    else $error("analog and digital align together");
  a_analog_first: assert property (o_analog_align |-> o_pulse_count inside {[3'h1:3'h4]})
    else $error("analog align outside pulses one to four");
  a_digital_last: assert property (o_digital_align |-> o_pulse_count inside {3'h5, 3'h6})
    else $error("digital align outside pulses five and six");
  a_synth_fifth: assert property (o_digital_align && o_pulse_count == 3'h5 |-> o_clk_src_synth)
    else $error("fifth pulse kept reference clock");
  a_done_sixth: assert property (o_digital_align && o_pulse_count == 3'h6 |-> done && o_state == 3'h3)
    else $error("sixth pulse did not reach done");
  a_count_step: assert property (!$stable(o_pulse_count) |->
    o_pulse_count == 3'h0 || o_pulse_count == $past(o_pulse_count) + 3'h1)
    else $error("pulse count jumped");
  a_align_cause: assert property (o_analog_align || o_digital_align |-> $past(sync_pulse, 1) ||
    $past(sync_pulse, 2) || $past(sync_pulse, 3) || $past(sync_pulse, 4))
    else $error("align without a sampled pulse");
  a_rate_answer: assert property (i_rate_valid |=> o_rate_done)
    else $error("rate request unanswered");
  a_rate_cause: assert property (o_rate_done |-> $past(i_rate_valid))
    else $error("rate result without request");
  a_ready_ref: assert property (o_state == 3'h1 && $past(o_state) == 3'h1 |-> !o_clk_src_synth)
    else $error("ready state not on reference clock");
  a_pulse_width: assert property ($rose(sync_pulse) |=> sync_pulse)
    else $error("sync pulse shorter than two cycles");
  // Five cycles is the shortest gap the bench source is built for
  a_gap_min: assert property ($fell(sync_pulse) |-> (!sync_pulse) [*5])
    else $error("sync pulse gap too short");
endmodule

//--- testbench/testbench.sv
// Testbench joining the pulse source and the device end over the link.
// Assumes a 20 MHz core clock; source waits shortened for run time.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic fall, to_rdy, rs, prim, rv, tune, start;
  logic ana, dig, synth, rdone, rok, rhp, lperr, busy, sdone;
  logic [2:0] cnt, st;
  logic [31:0] rate;
  logic [22:0] tkhz, lpf;
  logic [4:0] aq[$];
  logic [1:0] rq[$];
  logic [4:0] ea;
  logic [1:0] er;
  logic [31:0] rate_list [8] = '{32'h02faf080, 32'h032dcd55, 32'h032dcd56, 32'h03a98000, 32'h03a98001,
    32'h0, 32'h4e20, 32'h1e8480};
  int bad_count = 0;
  int tests_run = 0;
  always #25 i_core_clk = ~i_core_clk;
  mcsrx_link_if mcsrx_link_if_inst ();
  mcsrx_dev mcsrx_dev_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .link(mcsrx_link_if_inst),
    .i_edge_fall(fall), .i_to_ready(to_rdy), .i_restart(rs), .i_to_primed(prim), .i_rate_valid(rv),
    .i_rate_hz(rate), .i_lp_tune_en(tune), .i_lp_tune_khz(tkhz), .o_analog_align(ana),
    .o_digital_align(dig), .o_clk_src_synth(synth), .o_pulse_count(cnt), .o_state(st),
    .o_rate_done(rdone), .o_rate_ok(rok), .o_rate_hp_sel(rhp), .o_lp_freq_khz(lpf), .o_lp_tune_err(lperr));
  mcsrx_src #(.PULSE_W(2), .WAIT_SHORT(5), .WAIT_LONG(30)) mcsrx_src_inst (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .link(mcsrx_link_if_inst), .i_start(start), .o_busy(busy), .o_seq_done(sdone));
  mcsrx_asserts mcsrx_asserts_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .sync_pulse(mcsrx_link_if_inst.sync_pulse), .done(mcsrx_link_if_inst.done), .i_restart(rs),
    .i_rate_valid(rv), .o_analog_align(ana), .o_digital_align(dig), .o_clk_src_synth(synth),
    .o_pulse_count(cnt), .o_state(st), .o_rate_done(rdone));
  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // Six pulses from the source, each noted before it can arrive
  task automatic run_seq(logic f);
    int k;
    fall = f;
    for (k = 1; k <= 6; k++) aq.push_back({k <= 4, k > 4, 3'(k)});
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 400 && sdone !== 1'b1; k++) tick(1);
    if (sdone !== 1'b1) begin
      $display("ERROR seq_done exp 1 got 0");
      bad_count++;
      end_sim();
    end
    tick(4);
    `CHK("count", 3'h6, cnt)
    `CHK("state", 3'h3, st)
    `CHK("done", 1'b1, mcsrx_link_if_inst.done)
    `CHK("synth", 1'b1, synth)
    $display("test end: sequence, falling edge %0d", f);
  endtask
  task automatic send_rate(logic [31:0] r);
    longint x;
    logic ok;
    int z;
    x = longint'(r) * 64'h120;
    ok = r <= mcsrx_pkg::RATE_MAX_HZ;
    for (z = 0; z < 14; z++)
      if (x > mcsrx_pkg::ZONE_LO[z] * 64'hf4240 && x < mcsrx_pkg::ZONE_HI[z] * 64'hf4240) ok = 1'b0;
    rq.push_back({ok, 3 * longint'(r) > 64'h9896800});
    rate = r;
    rv = 1'b1;
    tick(1);
  endtask
  task automatic lp(logic en, logic [22:0] k, logic [22:0] f, logic err);
    tune = en;
    tkhz = k;
    tick(2);
    `CHK("lp freq", f, lpf)
    `CHK("lp err", err, lperr)
  endtask
  always @(posedge i_core_clk) begin
    #1;
    if ((ana | dig) !== 1'b0) begin
      ea = aq.size() ? aq.pop_front() : 5'hx;
      `CHK("align", ea, {ana, dig, cnt})
    end
    if (rdone !== 1'b0) begin
      er = rq.size() ? rq.pop_front() : 2'hx;
      `CHK("rate", er, {rok, rhp})
    end
  end
  initial begin
    void'($urandom(18957));
    {fall, to_rdy, rs, prim, rv, tune, start} = 7'h0;
    rate = 32'h0;
    tkhz = 23'h0;
    tick(3);
    i_resetn = 1'b1;
    `CHK("reset state", 3'h0, st)
    `CHK("reset lp", 23'h438000, lpf)
    start = 1'b1;
    tick(3);
    `CHK("start refused", 1'b0, busy)
    start = 1'b0;
    to_rdy = 1'b1;
    tick(1);
    to_rdy = 1'b0;
    tick(1);
    `CHK("ready", 3'h1, st)
    `CHK("ref clock", 1'b0, synth)
    `CHK("link ready", 1'b1, mcsrx_link_if_inst.ready)
    $display("test end: reset and ready");
    run_seq(1'b0);
    rs = 1'b1;
    tick(1);
    rs = 1'b0;
    tick(1);
    `CHK("restart count", 3'h0, cnt)
    run_seq(1'b1);
    prim = 1'b1;
    tick(1);
    prim = 1'b0;
    tick(1);
    `CHK("primed", 3'h4, st)
    to_rdy = 1'b1;
    tick(1);
    to_rdy = 1'b0;
    tick(1);
    `CHK("primed to ready", 3'h1, st)
    foreach (rate_list[i]) send_rate(rate_list[i]);
    repeat (6) send_rate($urandom % 32'h03c00000);
    rv = 1'b0;
    tick(3);
    $display("test end: rates");
    lp(1'b1, 23'h325aa0, 23'h325aa0, 1'b0);
    lp(1'b1, 23'h4c4b40, 23'h4c4b40, 1'b0);
    lp(1'b1, 23'h4c4b41, 23'h438000, 1'b1);
    lp(1'b0, 23'h325aa0, 23'h438000, 1'b0);
    $display("test end: low power synth");
    `CHK("align notes left", 0, aq.size())
    `CHK("rate notes left", 0, rq.size())
    end_sim();
  end
endmodule
